// ==== verification/csr_host_model.sv ====
// Behavioural host controller that drives the serial configuration link.
`default_nettype none
module csr_host_model (
    output logic sclk,
    output logic sel_n,
    output logic sdi,
    input wire logic sdo
);
    timeunit 1ns;
    timeprecision 1ps;
    // The link clock stands low outside frames and select rests high.
    initial begin
        sclk = 1'b0;
        sel_n = 1'b1;
        sdi = 1'b0;
    end
    // One bit of 200 ns, the data set 25 ns before each rising edge of the link clock.
    // The long high phase gives the sampled read-back bit time to settle before capture.
    task automatic bit_out(input logic b, output logic cap);
        sdi = b;
        #25 sclk = 1'b1;
        #150 sclk = 1'b0;
        cap = sdo;
        #25;
    endtask : bit_out
    // Opens a frame with setup time before the first edge.
    task automatic start();
        sel_n = 1'b0;
        #50;
    endtask : start
    // One word, address byte then data byte, most significant bit first.
    task automatic word(input logic [15:0] w, output logic [7:0] rd);
        logic c;
        for (int i = 15; i >= 0; i--) begin
            bit_out(w[i], c);
            if (i < 8) begin
                rd[i] = c;
            end
        end
    endtask : word
    // Twelve trailing bits that never complete a word.
    task automatic tail(input logic [11:0] t);
        logic c;
        for (int i = 11; i >= 0; i--) begin
            bit_out(t[i], c);
        end
    endtask : tail
    // Closes a frame; the released data line shows the inverse of its last bit.
    task automatic stop();
        #50 sel_n = 1'b1;
        sdi = ~sdi;
        #250;
    endtask : stop
    // A full word clocked while select stays high.
    task automatic idle_word(input logic [15:0] w);
        logic [7:0] d;
        word(w, d);
        sdi = ~sdi;
        #200;
    endtask : idle_word
endmodule : csr_host_model
`default_nettype wire

// ==== verification/tb.sv ====
// Self-checking testbench for the serial configuration port.
`default_nettype none
module tb;
    import csr_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic reset_pin = 1'b0;
    wire logic sclk;
    wire logic sel_n;
    wire logic sdi;
    logic out_line;
    logic out_oe;
    logic mode;
    // The read-back pin floats whenever the port does not drive it.
    wire logic sdo_pin = out_oe ? out_line : 1'bz;
    int bad_count = 0;
    int check_count = 0;
    logic [7:0] rd;
    always #12.5 clock = ~clock;
    csr_serial_port dut (.clock(clock), .rstn(rstn), .reset_pin(reset_pin),
        .serial_clk(sclk), .serial_select_n(sel_n), .serial_in_line(sdi),
        .serial_out_line_ff(out_line), .serial_out_oe_ff(out_oe), .readout_mode_ff(mode));
    csr_host_model host (.sclk(sclk), .sel_n(sel_n), .sdi(sdi), .sdo(sdo_pin));
    // Compares one byte and counts the outcome.
    task automatic check8(input logic [7:0] got, input logic [7:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check8
    // One single-word frame; the byte shifted back is returned.
    task automatic xfer(input logic [7:0] a, input logic [7:0] d, output logic [7:0] r);
        host.start();
        host.word({a, d}, r);
        host.stop();
    endtask : xfer
    // Prints the counts and the verdict, then ends the run.
    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : end_sim
    // Reset state, defaults and entering and leaving read-back.
    task automatic t_defaults();
        check8({7'h00, out_oe}, 8'h00, "oe after reset");
        xfer(CSR_ADDR_CTRL, 8'h01, rd);
        check8({6'h00, out_oe, mode}, 8'h03, "mode on");
        xfer(CSR_ADDR_45, 8'h00, rd);
        check8(rd, CSR_DEF_45, "default 45h");
        xfer(CSR_ADDR_CTRL, 8'h00, rd);
        check8(rd, 8'h00, "control read");
        check8({6'h00, out_oe, mode}, 8'h00, "mode off");
        $display("test defaults done");
    endtask : t_defaults
    // Clocks without select, two words in one frame and a broken tail.
    task automatic t_frame();
        host.idle_word({CSR_ADDR_CTRL, 8'h01});
        check8({7'h00, mode}, 8'h00, "unselected word");
        host.start();
        host.word(16'h12a5, rd);
        host.word(16'h343c, rd);
        host.tail(12'h12f);
        host.stop();
        xfer(CSR_ADDR_CTRL, 8'h01, rd);
        xfer(8'h12, 8'h00, rd);
        check8(rd, 8'ha5, "first word");
        xfer(8'h34, 8'h00, rd);
        check8(rd, 8'h3c, "second word");
        $display("test frame done");
    endtask : t_frame
    // Writes are refused in read-back mode apart from the control address.
    task automatic t_blocked();
        xfer(8'h12, 8'hff, rd);
        xfer(8'h12, 8'h00, rd);
        check8(rd, 8'ha5, "blocked write");
        xfer(CSR_ADDR_CTRL, 8'h00, rd);
        $display("test blocked done");
    endtask : t_blocked
    // Software reset clears the file and leaves the mode off.
    task automatic t_sw_reset();
        // Both bits set: the mode bit is taken, then the soft reset must clear it again.
        xfer(CSR_ADDR_CTRL, 8'h03, rd);
        check8({7'h00, mode}, 8'h00, "mode after soft reset");
        xfer(CSR_ADDR_CTRL, 8'h01, rd);
        xfer(8'h12, 8'h00, rd);
        check8(rd, CSR_DEF_ZERO, "soft reset 12h");
        xfer(CSR_ADDR_45, 8'h00, rd);
        check8(rd, CSR_DEF_45, "soft reset 45h");
        xfer(CSR_ADDR_CTRL, 8'h00, rd);
        $display("test soft reset done");
    endtask : t_sw_reset
    // A pulse of three clock cycles on the reset pin restores defaults.
    // The pin filter needs two agreeing samples, so a single-cycle pulse is not seen.
    task automatic t_hw_reset();
        xfer(8'h12, 8'h5a, rd);
        @(negedge clock) reset_pin = 1'b1;
        repeat (3) @(negedge clock);
        reset_pin = 1'b0;
        repeat (8) @(negedge clock);
        xfer(CSR_ADDR_CTRL, 8'h01, rd);
        xfer(8'h12, 8'h00, rd);
        check8(rd, CSR_DEF_ZERO, "pin reset 12h");
        xfer(CSR_ADDR_CTRL, 8'h00, rd);
        check8({7'h00, out_oe}, 8'h00, "oe released");
        $display("test pin reset done");
    endtask : t_hw_reset
    // Watchdog: a hang counts as a mismatch and closes the run.
    initial begin
        repeat (60000) @(posedge clock);
        bad_count++;
        end_sim();
    end
    // Main sequence: the bench resets the port before any configuration.
    initial begin
        repeat (12) @(negedge clock);
        rstn = 1'b1;
        repeat (4) @(negedge clock);
        t_defaults();
        t_frame();
        t_blocked();
        t_sw_reset();
        t_hw_reset();
        end_sim();
    end
endmodule : tb
`default_nettype wire

// ==== verilog/csr_pkg.sv ====
// Package of constants for the serial configuration port with read-back.
`default_nettype none
package csr_pkg;
    // Word layout: eight address bits, then eight data bits, MSB first.
    localparam int CSR_WORD_BITS = 16;
    localparam int CSR_FIELD_BITS = 8;
    localparam logic [4:0] CSR_CNT_ZERO = 5'h00;
    localparam logic [4:0] CSR_CNT_ADDR_DONE = 5'h08;
    localparam logic [4:0] CSR_CNT_WORD_DONE = 5'h10;
    localparam logic [4:0] CSR_CNT_ONE = 5'h01;
    // Control register address and its bit positions.
    localparam logic [7:0] CSR_ADDR_CTRL = 8'h00;
    localparam int CSR_BIT_READOUT = 0;
    localparam int CSR_BIT_SWRESET = 1;
    // Register that carries a non-zero default.
    localparam logic [7:0] CSR_ADDR_45 = 8'h45;
    localparam logic [7:0] CSR_DEF_45 = 8'h04;
    localparam logic [7:0] CSR_DEF_ZERO = 8'h00;
    // Reset pulse figure and its clock count at 40 MHz.
    localparam int CSR_CLK_MHZ = 40;
    localparam int CSR_RESET_MIN_NS = 10;
    localparam int CSR_RESET_MIN_CYC =
        ((CSR_RESET_MIN_NS * CSR_CLK_MHZ + 999) / 1000) < 1 ? 1 :
        ((CSR_RESET_MIN_NS * CSR_CLK_MHZ + 999) / 1000);
    // Number of registers in the file.
    localparam int CSR_NUM_REGS = 256;
endpackage : csr_pkg
`default_nettype wire

// ==== verilog/csr_regfile.sv ====
// Memory holding the 8-bit configuration registers with registered read data.
`default_nettype none
module csr_regfile
    import csr_pkg::*;
(
    input wire logic clock,
    input wire logic clear,
    input wire logic wr_en,
    input wire logic [7:0] wr_addr,
    input wire logic [7:0] wr_data,
    input wire logic [7:0] rd_addr,
    output logic [7:0] rd_data_ff
);
    // Storage array, one byte per address.
    logic [7:0] mem_ff [CSR_NUM_REGS];

    // Clear returns every register to its default; writes otherwise store.
    always_ff @(posedge clock) begin
        for (int i = 0; i < CSR_NUM_REGS; i++) begin
            if (clear) begin
                mem_ff[i] <= (i == int'(CSR_ADDR_45)) ? CSR_DEF_45 : CSR_DEF_ZERO;
            end else if (wr_en && (wr_addr == i[7:0])) begin
                mem_ff[i] <= wr_data;
            end
        end
    end

    // Read data always come from a register.
    always_ff @(posedge clock) begin
        rd_data_ff <= mem_ff[rd_addr];
    end
endmodule : csr_regfile
`default_nettype wire

// ==== verilog/csr_serial_port.sv ====
// Serial configuration port: word assembly, writes, resets and read-back.
`default_nettype none
module csr_serial_port
    import csr_pkg::*;
(
    input wire logic clock,
    input wire logic rstn,
    input wire logic reset_pin,
    input wire logic serial_clk,
    input wire logic serial_select_n,
    input wire logic serial_in_line,
    output logic serial_out_line_ff,
    output logic serial_out_oe_ff,
    output logic readout_mode_ff
);
    // Three-stage synchronisers for every pin; only stages 2 and 3 are compared.
    logic [2:0] sclk_sync_ff;
    logic [2:0] sel_sync_ff;
    logic [2:0] din_sync_ff;
    logic [2:0] rst_sync_ff;
    // Debounced, agreed levels of the pins.
    logic sclk_lvl_ff;
    logic sel_lvl_ff;
    logic rst_lvl_ff;
    // Edge strobes and select level derived from the agreed levels, and the data bit from the last synchroniser stage.
    logic sclk_fall;
    logic sclk_rise;
    logic sel_active;
    logic din_bit;
    // Shift state of the current word.
    logic [4:0] bit_cnt_ff;
    logic [15:0] shift_ff;
    logic [15:0] nxt_word;
    logic word_done;
    // Reset pin pulse width counter.
    logic [7:0] rst_cnt_ff;
    logic hw_reset;
    // Register file controls.
    logic sw_reset_ff;
    logic clear_regs;
    logic wr_en;
    logic [7:0] rd_data_ff;
    // Read-back output shifter.
    logic [7:0] out_shift_ff;
    logic out_load_ff;

    // Pins cross into the clock domain through three flip-flops.
    always_ff @(posedge clock) begin
        if (!rstn) begin
            sclk_sync_ff <= 3'h0;
            sel_sync_ff <= 3'h7;
            din_sync_ff <= 3'h0;
            rst_sync_ff <= 3'h0;
        end else begin
            sclk_sync_ff <= {sclk_sync_ff[1:0], serial_clk};
            sel_sync_ff <= {sel_sync_ff[1:0], serial_select_n};
            din_sync_ff <= {din_sync_ff[1:0], serial_in_line};
            rst_sync_ff <= {rst_sync_ff[1:0], reset_pin};
        end
    end

    // A level counts as changed only when stages two and three agree.
    always_ff @(posedge clock) begin
        if (!rstn) begin
            sclk_lvl_ff <= 1'b0;
            sel_lvl_ff <= 1'b1;
            rst_lvl_ff <= 1'b0;
        end else begin
            if (sclk_sync_ff[1] == sclk_sync_ff[2]) begin
                sclk_lvl_ff <= sclk_sync_ff[2];
            end
            if (sel_sync_ff[1] == sel_sync_ff[2]) begin
                sel_lvl_ff <= sel_sync_ff[2];
            end
            if (rst_sync_ff[1] == rst_sync_ff[2]) begin
                rst_lvl_ff <= rst_sync_ff[2];
            end
        end
    end

    // Edges of the shift clock; data bit is read from the settled stage.
    assign sclk_fall = sclk_lvl_ff && (sclk_sync_ff[1] == sclk_sync_ff[2]) && !sclk_sync_ff[2];
    assign sclk_rise = !sclk_lvl_ff && (sclk_sync_ff[1] == sclk_sync_ff[2]) && sclk_sync_ff[2];
    assign sel_active = !sel_lvl_ff;
    assign din_bit = din_sync_ff[2];
    // New word value with the incoming bit shifted in at the bottom.
    assign nxt_word = {shift_ff[14:0], din_bit};
    assign word_done = sel_active && sclk_fall && (bit_cnt_ff == CSR_CNT_WORD_DONE - CSR_CNT_ONE);

    // Shift register and bit counter; a select high drops any partial word.
    always_ff @(posedge clock) begin
        if (!rstn) begin
            bit_cnt_ff <= CSR_CNT_ZERO;
            shift_ff <= 16'h0000;
        end else if (!sel_active) begin
            bit_cnt_ff <= CSR_CNT_ZERO;
        end else if (sclk_fall) begin
            shift_ff <= nxt_word;
            if (word_done) begin
                bit_cnt_ff <= CSR_CNT_ZERO;
            end else begin
                bit_cnt_ff <= bit_cnt_ff + CSR_CNT_ONE;
            end
        end
    end

    // Reset pin must stay high for the minimum width before it clears registers.
    // Limitation: the pin filter only sees a pulse that spans two clock edges.
    always_ff @(posedge clock) begin
        if (!rstn || !rst_lvl_ff) begin
            rst_cnt_ff <= 8'h00;
        end else if (rst_cnt_ff != 8'hff) begin
            rst_cnt_ff <= rst_cnt_ff + 8'h01;
        end
    end
    assign hw_reset = rst_lvl_ff && (int'(rst_cnt_ff) + 1 >= CSR_RESET_MIN_CYC);

    // A write to address zero with bit one set raises a one-cycle soft reset.
    always_ff @(posedge clock) begin
        if (!rstn) begin
            sw_reset_ff <= 1'b0;
        end else begin
            sw_reset_ff <= word_done && (nxt_word[15:8] == CSR_ADDR_CTRL)
                && nxt_word[CSR_BIT_SWRESET];
        end
    end
    assign clear_regs = !rstn || hw_reset || sw_reset_ff;

    // Address zero stays writable in read-back mode; others are blocked.
    assign wr_en = word_done && (!readout_mode_ff || nxt_word[15:8] == CSR_ADDR_CTRL);

    // Read-back mode bit lives here; reset bit self-clears since it is not stored.
    always_ff @(posedge clock) begin
        if (clear_regs) begin
            readout_mode_ff <= 1'b0;
        end else if (word_done && nxt_word[15:8] == CSR_ADDR_CTRL) begin
            readout_mode_ff <= nxt_word[CSR_BIT_READOUT];
        end
    end

    // The register file; the read address is the address byte just received.
    csr_regfile u_regs (
        .clock(clock),
        .clear(clear_regs),
        .wr_en(wr_en),
        .wr_addr(nxt_word[15:8]),
        .wr_data(nxt_word[7:0]),
        .rd_addr(shift_ff[7:0]),
        .rd_data_ff(rd_data_ff)
    );

    // Flag that the eighth bit just arrived so the shifter loads on the next rising edge.
    always_ff @(posedge clock) begin
        if (!rstn) begin
            out_load_ff <= 1'b0;
        end else if (!sel_active) begin
            out_load_ff <= 1'b0;
        end else if (sclk_fall && bit_cnt_ff == CSR_CNT_ADDR_DONE - CSR_CNT_ONE) begin
            out_load_ff <= 1'b1;
        end else if (sclk_rise) begin
            out_load_ff <= 1'b0;
        end
    end

    // Output shifts on rising edges; the first data bit leaves on the rise after the address.
    // Register zero reads back as zeros because it holds the mode bits themselves.
    always_ff @(posedge clock) begin
        if (clear_regs) begin
            out_shift_ff <= 8'h00;
            serial_out_line_ff <= 1'b0;
        end else if (sel_active && sclk_rise && readout_mode_ff) begin
            if (out_load_ff) begin
                out_shift_ff <= (shift_ff[7:0] == CSR_ADDR_CTRL) ? 8'h00 : rd_data_ff;
                serial_out_line_ff <= (shift_ff[7:0] == CSR_ADDR_CTRL) ? 1'b0
                    : rd_data_ff[7];
            end else begin
                out_shift_ff <= {out_shift_ff[6:0], 1'b0};
                serial_out_line_ff <= out_shift_ff[6];
            end
        end
    end

    // The output driver is enabled only in read-back mode.
    always_ff @(posedge clock) begin
        if (!rstn) begin
            serial_out_oe_ff <= 1'b0;
        end else begin
            serial_out_oe_ff <= readout_mode_ff && !clear_regs;
        end
    end

    // Checks on the port behaviour.
    sequence s_word_to_ctrl_reset;
        word_done && nxt_word[15:8] == CSR_ADDR_CTRL && nxt_word[CSR_BIT_SWRESET];
    endsequence

    chk_swreset_clears_mode: assert property (@(posedge clock) disable iff (!rstn)
        s_word_to_ctrl_reset |=> ##1 !readout_mode_ff)
        else $error("soft reset did not clear read-back mode");
    chk_oe_off_normal: assert property (@(posedge clock) disable iff (!rstn)
        !readout_mode_ff |=> !serial_out_oe_ff)
        else $error("output driven while read-back is off");
    chk_select_high_idle: assert property (@(posedge clock) disable iff (!rstn)
        !sel_active |=> bit_cnt_ff == CSR_CNT_ZERO)
        else $error("bit count moved while select high");
    chk_write_blocked: assert property (@(posedge clock) disable iff (!rstn)
        readout_mode_ff && nxt_word[15:8] != CSR_ADDR_CTRL |-> !wr_en)
        else $error("write passed in read-back mode");
    chk_count_step: assert property (@(posedge clock) disable iff (!rstn)
        sel_active && sclk_fall && !word_done |=> bit_cnt_ff == $past(bit_cnt_ff) + CSR_CNT_ONE)
        else $error("bit count did not step on falling edge");
    chk_word_commit: assert property (@(posedge clock) disable iff (!rstn)
        word_done && !readout_mode_ff |-> wr_en ##1 bit_cnt_ff == CSR_CNT_ZERO)
        else $error("sixteenth bit did not commit");
    chk_no_partial_write: assert property (@(posedge clock) disable iff (!rstn)
        bit_cnt_ff != CSR_CNT_WORD_DONE - CSR_CNT_ONE |-> !wr_en)
        else $error("partial word wrote a register");
    chk_mode_set: assert property (@(posedge clock) disable iff (!rstn)
        word_done && nxt_word[15:8] == CSR_ADDR_CTRL && !nxt_word[CSR_BIT_SWRESET]
        && !hw_reset |=> readout_mode_ff == $past(nxt_word[CSR_BIT_READOUT]))
        else $error("read-back bit not taken from address zero");
endmodule : csr_serial_port
`default_nettype wire
